// ===== pkg/pmr_pkg.sv
package pmr_pkg;

    // ********************************************************
    // Register offsets
    // ********************************************************
    localparam logic [7:0] OFS_OUTPUT_MASK_CONTROL     = 8'h00;
    localparam logic [7:0] OFS_SLEEP_REQUEST_CONTROL   = 8'h01;
    localparam logic [7:0] OFS_STATE_AND_SUPPLY_STATUS = 8'h02;
    localparam logic [7:0] OFS_PIN_LEVEL_STATUS        = 8'h03;
    localparam logic [7:0] OFS_CURRENT_LIMIT_FLAGS     = 8'h04;
    localparam logic [7:0] OFS_OVERVOLTAGE_FLAGS       = 8'h05;
    localparam logic [7:0] RESET_VALUE_REG             = 8'h00;
    localparam logic [7:0] UNMAPPED_READ_VALUE         = 8'h00;

    // ********************************************************
    // Field positions
    // ********************************************************
    localparam int BIT_AUX_ONE_RESET_MASK       = 7;
    localparam int BIT_AUX_TWO_RESET_MASK       = 6;
    localparam int BIT_PRIMARY_RESET_MASK       = 5;
    localparam int BIT_POWER_OK_UNMASK          = 3;
    localparam int BIT_INTERRUPT_UNMASK         = 2;
    localparam int BIT_EXT_GOOD_FUNC_ENABLE     = 1;
    localparam int BIT_POWER_ENABLE_FUNC_ENABLE = 0;
    localparam int BIT_SLEEP_ENTRY_REQUEST      = 1;
    localparam int RAIL_COUNT                   = 7;

    // ********************************************************
    // Supervisor state codes and bus constants
    // ********************************************************
    localparam logic [2:0] STATE_CODE_RESET   = 3'h0;
    localparam logic [2:0] STATE_CODE_ACTIVE  = 3'h1;
    localparam logic [2:0] STATE_CODE_SLEEP   = 3'h2;
    localparam logic [2:0] STATE_CODE_THERMAL = 3'h4;
    localparam logic [2:0] STATE_CODE_FAULT   = 3'h5;
    localparam logic [3:0] BYTE_BITS          = 4'h8;

    typedef enum logic [2:0] {
        SUP_RESET,
        SUP_ACTIVE,
        SUP_SLEEP,
        SUP_THERMAL,
        SUP_FAULT
    } pmr_sup_e;

    typedef enum logic [3:0] {
        BUS_IDLE,
        BUS_ADDR,
        BUS_ADDR_ACK,
        BUS_PTR,
        BUS_PTR_ACK,
        BUS_WR,
        BUS_WR_ACK,
        BUS_RD,
        BUS_RD_ACK
    } pmr_bus_e;

endpackage

// ===== hdl/pmr_master_regs.sv
`timescale 1ns/1ps

module pmr_master_regs #(
    parameter logic [6:0] DEVICE_ADDR     = 7'h2A, // Serial address, value arbitrary
    parameter bit         SLEEP_AVAILABLE = 1'b0   // Sleep support in this configuration
) (
    input  wire logic       clk,                   // 10 MHz clock
    input  wire logic       rst_b,                 // Async reset, active low
    input  wire logic       sclIn,                 // Serial clock pin
    input  wire logic       sdaIn,                 // Serial data pin level
    output logic            sdaOut,                // Serial data drive value, always low
    output logic            sdaOe_b,               // Low while pulling data low
    input  wire logic       primaryGood,           // Primary reset supplies in regulation
    input  wire logic       auxOneGood,            // Aux one supplies in regulation
    input  wire logic       auxTwoGood,            // Aux two supplies in regulation
    input  wire logic       overTemp,              // Over-temperature comparator
    input  wire logic       tempWarn,              // Thermal warning comparator
    input  wire logic       vinOver,               // Input overvoltage comparator
    input  wire logic       vinUnder,              // Input undervoltage comparator
    input  wire logic       gpioPin,               // General-purpose pin level
    input  wire logic       modePin,               // Mode pin level
    input  wire logic       powerEnablePin,        // Power-enable pin level
    input  wire logic [6:0] railCurrentLimit,      // Per-rail current-limit comparators
    input  wire logic [6:0] railOverVoltage,       // Per-rail overvoltage comparators
    input  wire logic       powerEnablePolarity,   // 1 = power-enable pin active low
    input  wire logic       sleepSourceSelect,     // 1 = sleep by register
    input  wire logic       thermalUnmask,         // Allows thermal state, latches flag
    input  wire logic       overvoltageUnmask,     // Allows fault state on rail overvoltage
    output logic            primaryResetOut_b,     // Primary reset, active low
    output logic            auxOneResetOut_b,      // Aux one reset, active low
    output logic            auxTwoResetOut_b,      // Aux two reset, active low
    output logic            powerOkOut,            // Power-ok, active high
    output logic            interruptOut,          // Interrupt, active high
    output logic [2:0]      supStateCode           // Supervisor state code
);

    // Ten level inputs, two serial lines and two per-rail vectors
    localparam int ASYNC_W = 12 + 2 * pmr_pkg::RAIL_COUNT;

    typedef struct packed {
        logic [ASYNC_W-1:0] syncA;
        logic [ASYNC_W-1:0] syncB;
        logic               sclPrev;
        logic               sdaPrev;
        pmr_pkg::pmr_bus_e  busSt;
        logic [3:0]         bitCnt;
        logic [7:0]         shift;
        logic               rdMode;
        logic               hostAck;
        logic [7:0]         regPtr;
        logic               sdaRel;
        logic [7:0]         maskCtrl;
        logic [7:0]         sleepCtrl;
        logic               thermalShutdownFlag;
        logic               thermalWarningFlag;
        logic               inputOvervoltageFlag;
        logic               inputUndervoltageFlag;
        logic [6:0]         railCurrentLimitFlags;
        logic [6:0]         railOvervoltageFlags;
        pmr_pkg::pmr_sup_e  supSt;
        logic [2:0]         stateCode;
        logic               primRst_b;
        logic               auxOneRst_b;
        logic               auxTwoRst_b;
        logic               powerOk;
        logic               irq;
    } pmr_state_s;

    pmr_state_s s;
    pmr_state_s n;

    // ********************************************************
    // Synchronised views
    // ********************************************************
    logic       sclB;
    logic       sdaB;
    logic       primG;
    logic       auxOneG;
    logic       auxTwoG;
    logic       otemp;
    logic       twarn;
    logic       vov;
    logic       vuv;
    logic       gpioLvl;
    logic       modeLvl;
    logic       penLvl;
    logic [6:0] ilimIn;
    logic [6:0] ovIn;

    assign {primG, auxOneG, auxTwoG, otemp, twarn, vov, vuv, gpioLvl, modeLvl, penLvl, ilimIn, ovIn} = s.syncB[ASYNC_W-1:2];
    assign sclB = s.syncB[1];
    assign sdaB = s.syncB[0];

    logic       sclRise;
    logic       sclFall;
    logic       busStart;
    logic       busStop;
    logic       doLoad;
    logic       doWrite;
    logic [7:0] rdData;
    logic       clrStatus;
    logic       clrIlim;
    logic       clrOv;
    logic       penAsserted;
    logic       sleepReq;
    logic       inActive;

    assign sclRise  = sclB & ~s.sclPrev;
    assign sclFall  = ~sclB & s.sclPrev;
    assign busStart = sclB & s.sclPrev & s.sdaPrev & ~sdaB;
    assign busStop  = sclB & s.sclPrev & ~s.sdaPrev & sdaB;
    assign inActive = (s.supSt == pmr_pkg::SUP_ACTIVE);
    assign penAsserted = penLvl ^ powerEnablePolarity;
    // sleep gating, func enable bits otherwise unused
    assign sleepReq = SLEEP_AVAILABLE & s.sleepCtrl[pmr_pkg::BIT_SLEEP_ENTRY_REQUEST] & sleepSourceSelect
                      & s.maskCtrl[pmr_pkg::BIT_POWER_ENABLE_FUNC_ENABLE];

    // ********************************************************
    // Read mux
    // ********************************************************
    always_comb begin
        rdData = pmr_pkg::UNMAPPED_READ_VALUE;
        unique case (s.regPtr)
            pmr_pkg::OFS_OUTPUT_MASK_CONTROL: rdData = s.maskCtrl;
            pmr_pkg::OFS_SLEEP_REQUEST_CONTROL: rdData = s.sleepCtrl;
            pmr_pkg::OFS_STATE_AND_SUPPLY_STATUS: rdData = inActive ?
                {s.stateCode, penAsserted, s.thermalShutdownFlag, s.thermalWarningFlag,
                 s.inputOvervoltageFlag, s.inputUndervoltageFlag} : pmr_pkg::UNMAPPED_READ_VALUE;
            pmr_pkg::OFS_PIN_LEVEL_STATUS: rdData = {6'h00, gpioLvl, modeLvl};
            pmr_pkg::OFS_CURRENT_LIMIT_FLAGS: rdData = {1'b0, s.railCurrentLimitFlags};
            pmr_pkg::OFS_OVERVOLTAGE_FLAGS: rdData = {1'b0, s.railOvervoltageFlags};
            default: rdData = pmr_pkg::UNMAPPED_READ_VALUE;
        endcase
    end

    // ********************************************************
    // Next state
    // ********************************************************
    always_comb begin
        n = s;
        doLoad = 1'b0;
        doWrite = 1'b0;
        n.syncA = {primaryGood, auxOneGood, auxTwoGood, overTemp, tempWarn, vinOver, vinUnder,
                   gpioPin, modePin, powerEnablePin, railCurrentLimit, railOverVoltage, sclIn, sdaIn};
        n.syncB = s.syncA;
        n.sclPrev = sclB;
        n.sdaPrev = sdaB;
        if (busStart) begin
            n.busSt = pmr_pkg::BUS_ADDR;
            n.bitCnt = 4'h0;
            n.sdaRel = 1'b1;
        end else if (busStop) begin
            n.busSt = pmr_pkg::BUS_IDLE;
            n.sdaRel = 1'b1;
        end else begin
            unique case (s.busSt)
                pmr_pkg::BUS_IDLE: begin
                    n.sdaRel = 1'b1;
                end
                pmr_pkg::BUS_ADDR, pmr_pkg::BUS_PTR, pmr_pkg::BUS_WR: begin
                    if (sclRise) begin
                        n.shift = {s.shift[6:0], sdaB};
                        n.bitCnt = 4'(s.bitCnt + 4'h1);
                    end else if (sclFall && s.bitCnt == pmr_pkg::BYTE_BITS) begin
                        n.bitCnt = 4'h0;
                        n.sdaRel = 1'b0;
                        if (s.busSt == pmr_pkg::BUS_ADDR) begin
                            n.rdMode = s.shift[0];
                            n.busSt = pmr_pkg::BUS_ADDR_ACK;
                            if (s.shift[7:1] != DEVICE_ADDR) begin
                                n.busSt = pmr_pkg::BUS_IDLE;
                                n.sdaRel = 1'b1;
                            end
                        end else if (s.busSt == pmr_pkg::BUS_PTR) begin
                            n.regPtr = s.shift;
                            n.busSt = pmr_pkg::BUS_PTR_ACK;
                        end else begin
                            doWrite = 1'b1;
                            n.busSt = pmr_pkg::BUS_WR_ACK;
                        end
                    end
                end
                pmr_pkg::BUS_ADDR_ACK: begin
                    if (sclFall) begin
                        n.sdaRel = 1'b1;
                        n.busSt = pmr_pkg::BUS_PTR;
                        if (s.rdMode) begin
                            doLoad = 1'b1;
                        end
                    end
                end
                pmr_pkg::BUS_PTR_ACK, pmr_pkg::BUS_WR_ACK: begin
                    if (sclFall) begin
                        n.sdaRel = 1'b1;
                        n.busSt = pmr_pkg::BUS_WR;
                        if (s.busSt == pmr_pkg::BUS_WR_ACK) begin
                            n.regPtr = 8'(s.regPtr + 8'h01);
                        end
                    end
                end
                pmr_pkg::BUS_RD: begin
                    if (sclFall) begin
                        if (s.bitCnt == pmr_pkg::BYTE_BITS) begin
                            n.sdaRel = 1'b1;
                            n.bitCnt = 4'h0;
                            n.regPtr = 8'(s.regPtr + 8'h01);
                            n.busSt = pmr_pkg::BUS_RD_ACK;
                        end else begin
                            n.shift = {s.shift[6:0], 1'b1};
                            n.sdaRel = s.shift[6];
                            n.bitCnt = 4'(s.bitCnt + 4'h1);
                        end
                    end
                end
                pmr_pkg::BUS_RD_ACK: begin
                    if (sclRise) begin
                        n.hostAck = ~sdaB;
                    end else if (sclFall) begin
                        n.busSt = pmr_pkg::BUS_IDLE;
                        if (s.hostAck) begin
                            doLoad = 1'b1;
                        end
                    end
                end
                default: n.busSt = pmr_pkg::BUS_IDLE;
            endcase
        end
        if (doLoad) begin
            n.shift = rdData;
            n.sdaRel = rdData[7];
            n.bitCnt = 4'h1;
            n.busSt = pmr_pkg::BUS_RD;
        end
        if (doWrite && s.regPtr == pmr_pkg::OFS_OUTPUT_MASK_CONTROL) begin
            n.maskCtrl = s.shift;
        end
        if (doWrite && s.regPtr == pmr_pkg::OFS_SLEEP_REQUEST_CONTROL) begin
            n.sleepCtrl = s.shift;
        end

        // Read clears act on the byte handed out; a new event in that cycle still sets
        clrStatus = doLoad && s.regPtr == pmr_pkg::OFS_STATE_AND_SUPPLY_STATUS && inActive;
        clrIlim   = doLoad && s.regPtr == pmr_pkg::OFS_CURRENT_LIMIT_FLAGS;
        clrOv     = doLoad && s.regPtr == pmr_pkg::OFS_OVERVOLTAGE_FLAGS;
        n.thermalShutdownFlag = thermalUnmask ? ((s.thermalShutdownFlag & ~clrStatus) | otemp) : otemp;
        n.thermalWarningFlag = s.maskCtrl[pmr_pkg::BIT_INTERRUPT_UNMASK] ?
                               ((s.thermalWarningFlag & ~clrStatus) | twarn) : twarn;
        n.inputOvervoltageFlag = s.maskCtrl[pmr_pkg::BIT_POWER_OK_UNMASK] ?
                                 ((s.inputOvervoltageFlag & ~clrStatus) | vov) : vov;
        n.inputUndervoltageFlag = s.maskCtrl[pmr_pkg::BIT_POWER_OK_UNMASK] ?
                                  ((s.inputUndervoltageFlag & ~clrStatus) | vuv) : vuv;
        n.railCurrentLimitFlags = (s.railCurrentLimitFlags & ~{7{clrIlim}}) | ilimIn;
        n.railOvervoltageFlags = (s.railOvervoltageFlags & ~{7{clrOv}}) | ovIn;

        // ********************************************************
        // Supervisor
        // ********************************************************
        unique case (s.supSt)
            pmr_pkg::SUP_RESET: begin
                if (primG && !vov && !vuv) begin
                    n.supSt = pmr_pkg::SUP_ACTIVE;
                end
            end
            pmr_pkg::SUP_ACTIVE: begin
                if (otemp && thermalUnmask) begin
                    n.supSt = pmr_pkg::SUP_THERMAL;
                end else if (overvoltageUnmask && (|s.railOvervoltageFlags)) begin
                    n.supSt = pmr_pkg::SUP_FAULT;
                end else if (sleepReq) begin
                    n.supSt = pmr_pkg::SUP_SLEEP;
                end else if (!primG) begin
                    n.supSt = pmr_pkg::SUP_RESET;
                end
            end
            pmr_pkg::SUP_SLEEP: begin
                if (!sleepReq) begin
                    n.supSt = pmr_pkg::SUP_ACTIVE;
                end
            end
            pmr_pkg::SUP_THERMAL: begin
                if (!otemp) begin
                    n.supSt = pmr_pkg::SUP_RESET;
                end
            end
            pmr_pkg::SUP_FAULT: begin
                if (!(|s.railOvervoltageFlags)) begin
                    n.supSt = pmr_pkg::SUP_RESET;
                end
            end
            default: n.supSt = pmr_pkg::SUP_RESET;
        endcase
        unique case (n.supSt)
            pmr_pkg::SUP_ACTIVE:  n.stateCode = pmr_pkg::STATE_CODE_ACTIVE;
            pmr_pkg::SUP_SLEEP:   n.stateCode = pmr_pkg::STATE_CODE_SLEEP;
            pmr_pkg::SUP_THERMAL: n.stateCode = pmr_pkg::STATE_CODE_THERMAL;
            pmr_pkg::SUP_FAULT:   n.stateCode = pmr_pkg::STATE_CODE_FAULT;
            default:              n.stateCode = pmr_pkg::STATE_CODE_RESET;
        endcase

        n.primRst_b = s.maskCtrl[pmr_pkg::BIT_PRIMARY_RESET_MASK] | primG;
        n.auxOneRst_b = s.maskCtrl[pmr_pkg::BIT_AUX_ONE_RESET_MASK] | auxOneG;
        n.auxTwoRst_b = s.maskCtrl[pmr_pkg::BIT_AUX_TWO_RESET_MASK] | auxTwoG;
        n.powerOk = s.maskCtrl[pmr_pkg::BIT_POWER_OK_UNMASK] & primG & auxOneG & auxTwoG & ~vov & ~vuv;
        n.irq = s.maskCtrl[pmr_pkg::BIT_INTERRUPT_UNMASK]
                & ((|s.railCurrentLimitFlags) | (|s.railOvervoltageFlags));
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
            s.sdaRel <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign sdaOut            = 1'b0;
    assign sdaOe_b           = s.sdaRel;
    assign primaryResetOut_b = s.primRst_b;
    assign auxOneResetOut_b  = s.auxOneRst_b;
    assign auxTwoResetOut_b  = s.auxTwoRst_b;
    assign powerOkOut        = s.powerOk;
    assign interruptOut      = s.irq;
    assign supStateCode      = s.stateCode;

    // ********************************************************
    // Checks
    // ********************************************************
    a_prim_reset_mask: assert property (@(posedge clk) disable iff (!rst_b)
        $past(s.maskCtrl[pmr_pkg::BIT_PRIMARY_RESET_MASK]) |-> primaryResetOut_b)
        else $error("primary reset asserted while masked");
    a_power_ok_mask: assert property (@(posedge clk) disable iff (!rst_b)
        !$past(s.maskCtrl[pmr_pkg::BIT_POWER_OK_UNMASK]) |-> !powerOkOut)
        else $error("power-ok driven while masked");
    a_irq_gated_or: assert property (@(posedge clk) disable iff (!rst_b)
        ##1 interruptOut == ($past(s.maskCtrl[pmr_pkg::BIT_INTERRUPT_UNMASK])
            && ($past(s.railCurrentLimitFlags) != 7'h00 || $past(s.railOvervoltageFlags) != 7'h00)))
        else $error("interrupt not gated OR of flags");
    a_no_sleep_entry: assert property (@(posedge clk) disable iff (!rst_b)
        !SLEEP_AVAILABLE |-> s.supSt != pmr_pkg::SUP_SLEEP)
        else $error("sleep entered while unavailable");
    a_ilim_hold: assert property (@(posedge clk) disable iff (!rst_b)
        !clrIlim |=> ((s.railCurrentLimitFlags & $past(s.railCurrentLimitFlags)) == $past(s.railCurrentLimitFlags)))
        else $error("current-limit flag lost without read");
    a_ov_fault_entry: assert property (@(posedge clk) disable iff (!rst_b)
        (inActive && !(otemp && thermalUnmask) && overvoltageUnmask && s.railOvervoltageFlags != 7'h00)
        |=> s.supSt == pmr_pkg::SUP_FAULT && supStateCode == pmr_pkg::STATE_CODE_FAULT)
        else $error("overvoltage did not force fault state");
    a_fault_needs_unmask: assert property (@(posedge clk) disable iff (!rst_b)
        (inActive && !overvoltageUnmask) |=> s.supSt != pmr_pkg::SUP_FAULT)
        else $error("fault entered with overvoltage masked");
    a_thermal_needs_unmask: assert property (@(posedge clk) disable iff (!rst_b)
        (inActive && !thermalUnmask) |=> s.supSt != pmr_pkg::SUP_THERMAL)
        else $error("thermal entered with thermal masked");
    a_tsd_live: assert property (@(posedge clk) disable iff (!rst_b)
        !thermalUnmask |=> s.thermalShutdownFlag == $past(otemp))
        else $error("thermal flag not live while masked");
    a_state_read_blank: assert property (@(posedge clk) disable iff (!rst_b)
        (doLoad && !inActive && s.regPtr == pmr_pkg::OFS_STATE_AND_SUPPLY_STATUS) |=> s.shift == 8'h00)
        else $error("state register readable outside active");

endmodule

// ===== tb/pmr_i2c_host.sv
`timescale 1ns/1ps
// ****************************************
// Serial host controller model
// ****************************************
module pmr_i2c_host #(
    parameter logic [6:0] DEV_ADDR = 7'h2A // Device address, value arbitrary
) (
    input  wire logic clk,    // Bench clock
    input  wire logic sda,    // Resolved data wire, pulled up
    output logic      scl,    // Serial clock, idles high
    output logic      sdaOe_b // Low while pulling data low
);
    initial begin
        scl = 1'h1;
        sdaOe_b = 1'h1;
    end
    // Eight-cycle phases stay well clear of the four-cycle minimum
    task automatic hp;
        repeat (8) @(negedge clk);
    endtask
    // Start when s1 is low, stop when s1 is high; both begin with clock low or idle
    task automatic cond(input logic s0, input logic s1);
        sdaOe_b = s0;
        hp();
        scl = 1'h1;
        hp();
        sdaOe_b = s1;
        hp();
        scl = s1;
    endtask
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
        logic [8:0] s;
        for (int i = 8; i >= 0; i--) begin
            sdaOe_b = (i > 0) ? tx[i - 1] : 1'h1;
            hp();
            scl = 1'h1;
            hp();
            s[i] = sda;
            scl = 1'h0;
        end
        rx = s[8:1];
        ack = ~s[0];
    endtask
    task automatic wrReg(input logic [7:0] ofs, input logic [7:0] d, output logic ok);
        logic [7:0] r;
        logic [2:0] a;
        cond(1'h1, 1'h0);
        xfer({DEV_ADDR, 1'h0}, r, a[0]);
        xfer(ofs, r, a[1]);
        xfer(d, r, a[2]);
        cond(1'h0, 1'h1);
        ok = &a;
    endtask
    // Single byte read, ended by a refusal of the last byte
    task automatic rdReg(input logic [7:0] ofs, output logic [7:0] d);
        logic [7:0] r;
        logic       a;
        cond(1'h1, 1'h0);
        xfer({DEV_ADDR, 1'h0}, r, a);
        xfer(ofs, r, a);
        cond(1'h1, 1'h0);
        xfer({DEV_ADDR, 1'h1}, r, a);
        xfer(8'hFF, d, a);
        cond(1'h0, 1'h1);
    endtask
endmodule

// ===== tb/pmr_master_regs_test.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin nCompared++; if ((g) !== (e)) begin failCount++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module pmr_master_regs_test;
    logic       clk = 0, rst_b = 0, sclIn, hostOe_b, sdaOe_b, powerOkOut, interruptOut, ok;
    logic       primaryGood = 1, auxOneGood = 1, auxTwoGood = 1, overTemp = 0, tempWarn = 0, vinOver = 0;
    logic       vinUnder = 0, gpioPin = 0, modePin = 0, powerEnablePin = 0, powerEnablePolarity = 0;
    logic       sleepSourceSelect = 0, thermalUnmask = 0, overvoltageUnmask = 0;
    logic       primaryResetOut_b, auxOneResetOut_b, auxTwoResetOut_b;
    logic [6:0] railCurrentLimit = 7'h00, railOverVoltage = 7'h00;
    logic [2:0] supStateCode;
    logic [7:0] rd;
    int         failCount = 0, nCompared = 0;
    // Open-drain data wire with pull-up
    wire        sdaIn = hostOe_b & sdaOe_b;
    pmr_master_regs u_pmr_master_regs (.clk, .rst_b, .sclIn, .sdaIn, .sdaOut(), .sdaOe_b, .primaryGood,
        .auxOneGood, .auxTwoGood, .overTemp, .tempWarn, .vinOver, .vinUnder, .gpioPin, .modePin,
        .powerEnablePin, .railCurrentLimit, .railOverVoltage, .powerEnablePolarity, .sleepSourceSelect,
        .thermalUnmask, .overvoltageUnmask, .primaryResetOut_b, .auxOneResetOut_b, .auxTwoResetOut_b,
        .powerOkOut, .interruptOut, .supStateCode);
    pmr_i2c_host u_pmr_i2c_host (.clk, .sda(sdaIn), .scl(sclIn), .sdaOe_b(hostOe_b));
    always #50 clk = ~clk;
    task automatic giveVerdict;
        if (failCount == 0 && nCompared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Synchroniser plus output register need three edges; six leaves margin
    task automatic w6;
        repeat (6) @(negedge clk);
    endtask
    task automatic rdChk(input logic [7:0] ofs, input logic [7:0] e);
        u_pmr_i2c_host.rdReg(ofs, rd);
        `CHK("read", e, rd)
    endtask
    task automatic wrChk(input logic [7:0] ofs, input logic [7:0] d);
        u_pmr_i2c_host.wrReg(ofs, d, ok);
        `CHK("ack", 1'h1, ok)
        w6();
    endtask
    task automatic tRegs;
        for (int i = 0; i < 8; i++) rdChk(8'(i), (i == 2) ? 8'h20 : 8'h00);
        wrChk(8'h01, 8'h02);
        `CHK("sleep", 3'h1, supStateCode)
        rdChk(8'h01, 8'h02);
    endtask
    task automatic tMasks;
        wrChk(8'h00, 8'hEB);
        rdChk(8'h00, 8'hEB);
        `CHK("pokOn", 1'h1, powerOkOut)
        // Every sleep condition but availability is now met
        sleepSourceSelect = 1;
        w6();
        `CHK("noSleep", 3'h1, supStateCode)
        auxOneGood = 0;
        auxTwoGood = 0;
        w6();
        `CHK("auxMasked", 2'h3, {auxOneResetOut_b, auxTwoResetOut_b})
        wrChk(8'h00, 8'h00);
        `CHK("auxOut", 2'h0, {auxOneResetOut_b, auxTwoResetOut_b})
        auxOneGood = 1;
        auxTwoGood = 1;
        w6();
        `CHK("pokOff", 1'h0, powerOkOut)
    endtask
    task automatic tFlags;
        railCurrentLimit = 7'h08;
        w6();
        railCurrentLimit = 7'h00;
        w6();
        `CHK("irqMask", 1'h0, interruptOut)
        wrChk(8'h00, 8'h04);
        `CHK("irqOn", 1'h1, interruptOut)
        rdChk(8'h04, 8'h08);
        rdChk(8'h04, 8'h00);
        w6();
        `CHK("irqOff", 1'h0, interruptOut)
    endtask
    task automatic tOver;
        railOverVoltage = 7'h40;
        w6();
        railOverVoltage = 7'h00;
        w6();
        `CHK("noFault", 3'h1, supStateCode)
        `CHK("irqOv", 1'h1, interruptOut)
        overvoltageUnmask = 1;
        w6();
        `CHK("fault", 3'h5, supStateCode)
        rdChk(8'h02, 8'h00);
        rdChk(8'h05, 8'h40);
        overvoltageUnmask = 0;
        w6();
        `CHK("back", 3'h1, supStateCode)
    endtask
    task automatic tStatus;
        powerEnablePin = 1;
        powerEnablePolarity = 1;
        gpioPin = 1;
        overTemp = 1;
        w6();
        `CHK("noTherm", 3'h1, supStateCode)
        rdChk(8'h02, 8'h28);
        rdChk(8'h03, 8'h02);
        powerEnablePolarity = 0;
        overTemp = 0;
        w6();
        rdChk(8'h02, 8'h30);
    endtask
    task automatic tLatch;
        wrChk(8'h00, 8'h0C);
        vinOver = 1;
        vinUnder = 1;
        tempWarn = 1;
        w6();
        vinOver = 0;
        vinUnder = 0;
        tempWarn = 0;
        w6();
        rdChk(8'h02, 8'h37);
        rdChk(8'h02, 8'h30);
    endtask
    // Tests take about 15k cycles; the limit is over twice that
    initial begin
        repeat (40000) @(posedge clk);
        failCount++;
        giveVerdict();
    end
    initial begin
        repeat (20) @(negedge clk);
        `CHK("rstOuts", 4'h0, {primaryResetOut_b, auxOneResetOut_b, auxTwoResetOut_b, interruptOut})
        rst_b = 1;
        w6();
        tRegs();
        tMasks();
        tFlags();
        tOver();
        tStatus();
        tLatch();
        giveVerdict();
    end
endmodule
